// ### frcu_core.sv
// Register command unit of a serial flash: status, config and page registers
//
// Overview of operation
// RL1: Opcode 05h reads status one, even busy
// RL2: Read repeats every byte with fresh status
// RL3: Opcode 07h reads status two, repeating
// RL4: Opcode 35h reads configuration, repeating
// RL5: Opcode 16h reads page register, repeating
// RL6: Opcode 17h loads page register, no enable
// RL7: Extended bit zero selects page address bits
// RL8: Page write keeps error and busy flags
// RL9: Host writes reserved page bits as zero
// RL10: After B9h, write-registers loads page low bits
// RL11: That write closes access, keeps extended bit
// RL12: Any other frame closes page access
// RL13: Page access only idle, no error flags
// RL14: Write-registers needs write-enable latch set
// RL15: Failed register write sets error flag
// RL16: Read-only kept, one-time bits only set
// RL17: Write-registers needs 8, 16 or 24 bits
// RL18: Quad mode forbids single-byte write-registers
// RL19: Deselect starts timed write, busy meanwhile
// RL20: Volatile write short, non-volatile write long
// RL21: Write completion clears write-enable latch
// RL22: Protect bit plus low pin rejects writes
// RL23: Opcode 06h with exactly eight bits sets latch
// RL24: Quad mode disables pin write protection
`timescale 1ns/100ps
module frcu_core import frcu_pkg::*; #(
  parameter int TW_CYCLES = T_W_CYC,
  parameter int TCS_CYCLES = T_CS_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe_n,
  input wire logic wp_n,
  input wire logic embedded_busy,
  input wire logic reg_write_fault,
  output logic ext_addr_en,
  output logic [1:0] page_addr_bits,
  output logic quad_enable,
  output logic [2:0] block_protect
);
  localparam int TMR_W = $clog2(TW_CYCLES + 1);

  // Counts the logic cannot serve
  if (TW_CYCLES < 1 || TCS_CYCLES < 1 || TCS_CYCLES > TW_CYCLES) begin : bad_timing
    $error("frcu_core: write times must be at least one cycle, short below long");
  end

  frcu_link_if lk ();

  frcu_state_type state;
  logic [7:0] sr1;
  logic [7:0] sr2;
  logic [7:0] cr;
  logic [7:0] page;
  logic [TMR_W-1:0] timer;
  logic nv_write;
  logic cs_s1;
  logic cs_s2;
  logic cs_s3;
  logic wp_s1;
  logic wp_s2;
  logic ack_s1;
  logic ack_s2;
  logic cs_rise;
  logic [5:0] dbits;
  logic len_ok;
  logic fmt_ok;
  logic hw_protect;
  logic regs_frame;
  logic regs_go;
  logic latch_go;
  logic page_open_go;
  logic page_regs;
  logic page_direct;
  logic [7:0] sr1_view;
  logic [7:0] next_sr1;
  logic [7:0] next_cr;
  logic [7:0] next_sr2;

  // Merge written data: read-only bits keep old, one-time bits can only rise
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wr,
                                       input logic [7:0] ro, input logic [7:0] otp);
    merge = (old & ro) | ((old | wr) & otp) | (wr & ~ro & ~otp);
  endfunction

  frcu_link u_link (
    .sck(sck),
    .nrst(nrst),
    .cs_n(cs_n),
    .si(si),
    .so(so),
    .so_oe_n(so_oe_n),
    .lk(lk.link)
  );

  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      wp_s1 <= 1'b1;
      wp_s2 <= 1'b1;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      wp_s1 <= wp_n;
      wp_s2 <= wp_s1;
      ack_s1 <= lk.ack_tgl;
      ack_s2 <= ack_s1;
    end
  end

  // Frame end seen in this domain; the link holds its capture while deselected
  assign cs_rise = cs_s2 & ~cs_s3;
  assign dbits = lk.nbits - BITS_OPCODE;

  // RL17: only whole one, two or three data bytes are executed
  assign len_ok = (lk.nbits == BITS_ONE) || (lk.nbits == BITS_TWO) || (lk.nbits == BITS_THREE);
  // RL18: quad mode needs at least two data bytes
  assign fmt_ok = len_ok && !(cr[CR_QUAD] && dbits == 6'h08);
  // RL22: protect bit with low pin rejects the write
  // RL24: in quad mode the pin is a data line, so no hardware protection
  assign hw_protect = sr1[SR1_SWD] & ~wp_s2 & ~cr[CR_QUAD];
  assign regs_frame = cs_rise && (lk.op == OP_WR_REGS) && (state == ST_IDLE);
  // RL14: write-registers runs only with the latch set
  assign regs_go = regs_frame && sr1[SR1_LATCH] && !embedded_busy && fmt_ok && !hw_protect;
  // RL23: write enable only when deselected right after the opcode
  assign latch_go = cs_rise && (lk.op == OP_WR_ENABLE) && (lk.nbits == BITS_OPCODE) &&
                   (state != ST_WRITING);
  // RL13: page access refused while busy or with an error flag set
  assign page_open_go = cs_rise && (lk.op == OP_PAGE_ACCESS) && (lk.nbits == BITS_OPCODE) &&
                        (state == ST_IDLE) && !embedded_busy &&
                        !sr1[SR1_P_ERR] && !sr1[SR1_E_ERR];
  // RL10: write-registers straight after page access targets the page register
  assign page_regs = cs_rise && (state == ST_PAGE_OPEN) && (lk.op == OP_WR_REGS) &&
                    (lk.nbits >= BITS_ONE);
  // RL6: direct page write needs no write enable
  assign page_direct = cs_rise && (lk.op == OP_WR_PAGE) && (lk.nbits >= BITS_ONE);

  // New register values for an accepted write, by frame length
  always_comb begin
    next_sr1 = sr1;
    next_cr = cr;
    next_sr2 = sr2;
    // RL16: read-only and one-time bits are protected by the merge
    next_sr1 = merge(sr1, lk.d0, SR1_RO_MASK, SR1_OTP_MASK);
    if (lk.nbits >= BITS_TWO) begin
      next_cr = merge(cr, lk.d1, CR_RO_MASK, CR_OTP_MASK);
    end
    if (lk.nbits == BITS_THREE) begin
      next_sr2 = merge(sr2, lk.d2, SR2_RO_MASK, SR2_OTP_MASK);
    end
  end

  // Command state: page access window and self-timed write
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (page_open_go) begin
            state <= ST_PAGE_OPEN;
          end else if (regs_go) begin
            // RL19: deselect starts the timed write
            state <= ST_WRITING;
          end
        end
        ST_PAGE_OPEN: begin
          // RL11: page write ends access
          // RL12: any frame end closes access
          if (cs_rise) begin
            state <= ST_IDLE;
          end
        end
        ST_WRITING: begin
          if (timer == '0) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Write timer; volatile-only writes last TCS_CYCLES cycles, others TW_CYCLES
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      timer <= '0;
      nv_write <= 1'b0;
    end else if (regs_go) begin
      nv_write <= |(((next_sr1 ^ sr1) & SR1_NV_MASK) | ((next_cr ^ cr) & CR_NV_MASK) |
                    ((next_sr2 ^ sr2) & SR2_NV_MASK));
      // RL20: long time only when a non-volatile bit changes
      if (|(((next_sr1 ^ sr1) & SR1_NV_MASK) | ((next_cr ^ cr) & CR_NV_MASK) |
            ((next_sr2 ^ sr2) & SR2_NV_MASK))) begin
        timer <= TMR_W'(TW_CYCLES - 1);
      end else begin
        timer <= TMR_W'(TCS_CYCLES - 1);
      end
    end else if (state == ST_WRITING && timer != '0) begin
      timer <= timer - 1'b1;
    end
  end

  // Status one: busy, latch, protect bits and error flags
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sr1 <= SR1_RST;
    end else if (regs_go) begin
      sr1 <= next_sr1;
      sr1[SR1_BUSY] <= 1'b1;
    end else if (state == ST_WRITING && timer == '0) begin
      sr1[SR1_BUSY] <= 1'b0;
      // RL21: completion clears the latch
      sr1[SR1_LATCH] <= 1'b0;
      // RL15: a failing write reports through the program error flag
      if (reg_write_fault) begin
        sr1[SR1_P_ERR] <= 1'b1;
      end
    end else if (latch_go) begin
      sr1[SR1_LATCH] <= 1'b1;
    end
  end

  // Configuration and status two follow the accepted write
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cr <= CR_RST;
      sr2 <= SR2_RST;
    end else if (regs_go) begin
      cr <= next_cr;
      sr2 <= next_sr2;
    end
  end

  // Page register; neither path touches status one
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      page <= PAGE_RST;
    end else if (page_regs) begin
      // RL10: low two bits only, rest and second byte dropped
      page <= (page & ~PAGE_ACC_MASK) | (lk.d0 & PAGE_ACC_MASK);
    end else if (page_direct) begin
      // RL8: status one is not written here
      // RL9: reserved bits are not stored, so a stray one is harmless
      page <= lk.d0 & PAGE_WR_MASK;
    end
  end

  // Status view: busy also reflects array operations elsewhere in the chip
  assign sr1_view = sr1 | {7'h00, embedded_busy};

  // RL1: snapshot handshake; values held stable until the link acknowledges
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lk.req_tgl <= 1'b0;
      lk.snap_sr1 <= SR1_RST;
      lk.snap_sr2 <= SR2_RST;
      lk.snap_cr <= CR_RST;
      lk.snap_page <= PAGE_RST;
    end else if (ack_s2 == lk.req_tgl) begin
      lk.snap_sr1 <= sr1_view;
      lk.snap_sr2 <= sr2;
      lk.snap_cr <= cr;
      lk.snap_page <= page;
      lk.req_tgl <= ~lk.req_tgl;
    end
  end

  // RL7: page bits extend three-byte addresses only when extended bit is zero
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ext_addr_en <= 1'b0;
      page_addr_bits <= 2'h0;
      quad_enable <= 1'b0;
      block_protect <= 3'h0;
    end else begin
      ext_addr_en <= page[PAGE_EXT];
      page_addr_bits <= page[PAGE_EXT] ? 2'h0 : page[1:0];
      quad_enable <= cr[CR_QUAD];
      block_protect <= sr1[SR1_BP_LO +: 3];
    end
  end

  // Checks on the core behaviour
  latch_set_a: assert property (@(posedge mclk) disable iff (!nrst) // RL23
    latch_go |=> sr1[SR1_LATCH])
    else $error("write enable did not set the latch");

  regs_need_latch_a: assert property (@(posedge mclk) disable iff (!nrst) // RL14
    regs_frame && !sr1[SR1_LATCH] |=> state != ST_WRITING)
    else $error("register write started without latch");

  bad_length_a: assert property (@(posedge mclk) disable iff (!nrst) // RL17
    regs_frame && !len_ok |=> $stable(sr1) && $stable(cr) && state == ST_IDLE)
    else $error("bad length register write executed");

  quad_single_a: assert property (@(posedge mclk) disable iff (!nrst) // RL18
    regs_frame && cr[CR_QUAD] && lk.nbits == BITS_ONE |=> state != ST_WRITING)
    else $error("single byte write accepted in quad mode");

  hw_protect_a: assert property (@(posedge mclk) disable iff (!nrst) // RL22
    regs_frame && sr1[SR1_SWD] && !wp_s2 && !cr[CR_QUAD] |=> $stable(cr) && !sr1[SR1_BUSY])
    else $error("protected register write accepted");

  busy_window_a: assert property (@(posedge mclk) disable iff (!nrst) // RL19
    regs_go |=> sr1[SR1_BUSY] && state == ST_WRITING)
    else $error("accepted write did not raise busy");

  volatile_fast_a: assert property (@(posedge mclk) disable iff (!nrst) // RL20
    $rose(sr1[SR1_BUSY]) && !nv_write |-> ##[1:8] !sr1[SR1_BUSY])
    else $error("volatile write took too long");

  done_clears_latch_a: assert property (@(posedge mclk) disable iff (!nrst) // RL21
    $fell(sr1[SR1_BUSY]) |-> !sr1[SR1_LATCH])
    else $error("latch still set after write");

  page_keeps_sr_a: assert property (@(posedge mclk) disable iff (!nrst) // RL8
    page_direct && state == ST_IDLE |=> $stable(sr1) && page == ($past(lk.d0) & PAGE_WR_MASK))
    else $error("page write disturbed status or failed");

  page_close_a: assert property (@(posedge mclk) disable iff (!nrst) // RL12
    cs_rise && state == ST_PAGE_OPEN |=> state == ST_IDLE)
    else $error("page access stayed open");

  ext_keep_a: assert property (@(posedge mclk) disable iff (!nrst) // RL11
    page_regs |=> page[PAGE_EXT] == $past(page[PAGE_EXT]) && page[1:0] == $past(lk.d0[1:0]))
    else $error("page access write altered extended bit");

  page_legal_a: assert property (@(posedge mclk) disable iff (!nrst) // RL13
    state == ST_IDLE && (embedded_busy || sr1[SR1_P_ERR] || sr1[SR1_E_ERR]) |=>
      state != ST_PAGE_OPEN)
    else $error("page access opened while illegal");
endmodule

// ### frcu_pkg.sv
// Shared constants and types for the flash register command unit
package frcu_pkg;
  // Opcodes handled by this unit
  localparam logic [7:0] OP_RD_STATUS_ONE = 8'h05;
  localparam logic [7:0] OP_RD_STATUS_TWO = 8'h07;
  localparam logic [7:0] OP_RD_CONFIG = 8'h35;
  localparam logic [7:0] OP_RD_PAGE = 8'h16;
  localparam logic [7:0] OP_WR_PAGE = 8'h17;
  localparam logic [7:0] OP_PAGE_ACCESS = 8'hb9;
  localparam logic [7:0] OP_WR_REGS = 8'h01;
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;

  // Field positions in status one, configuration and page registers
  localparam int SR1_BUSY = 0;
  localparam int SR1_LATCH = 1;
  localparam int SR1_BP_LO = 2;
  localparam int SR1_E_ERR = 5;
  localparam int SR1_P_ERR = 6;
  localparam int SR1_SWD = 7;
  localparam int CR_QUAD = 1;
  localparam int PAGE_EXT = 7;

  // Bit counts of a frame: opcode, then one, two or three data bytes
  localparam logic [5:0] BITS_OPCODE = 6'h08;
  localparam logic [5:0] BITS_ONE = 6'h10;
  localparam logic [5:0] BITS_TWO = 6'h18;
  localparam logic [5:0] BITS_THREE = 6'h20;
  localparam logic [5:0] CNT_LAST = 6'h3f;
  localparam logic [5:0] CNT_WRAP = 6'h38;

  // Write masks: read-only bits keep their value, one-time bits only set
  localparam logic [7:0] SR1_RO_MASK = 8'h63;
  localparam logic [7:0] SR1_OTP_MASK = 8'h00;
  localparam logic [7:0] CR_RO_MASK = 8'h00;
  localparam logic [7:0] CR_OTP_MASK = 8'h00;
  localparam logic [7:0] SR2_RO_MASK = 8'h00;
  localparam logic [7:0] SR2_OTP_MASK = 8'h00;
  localparam logic [7:0] SR1_NV_MASK = 8'h9c;
  localparam logic [7:0] CR_NV_MASK = 8'hfd;
  localparam logic [7:0] SR2_NV_MASK = 8'h00;
  localparam logic [7:0] PAGE_WR_MASK = 8'h83;
  localparam logic [7:0] PAGE_ACC_MASK = 8'h03;

  // Reset values
  localparam logic [7:0] SR1_RST = 8'h00;
  localparam logic [7:0] SR2_RST = 8'h00;
  localparam logic [7:0] CR_RST = 8'h00;
  localparam logic [7:0] PAGE_RST = 8'h00;

  // Timing: system clock and the two completion times of a register write
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_CS_NS = 50;
  localparam int T_W_NS = 200000;
  localparam int T_CS_CYC = (T_CS_NS / CLK_PERIOD_NS < 1) ? 1 : T_CS_NS / CLK_PERIOD_NS;
  localparam int T_W_CYC = (T_W_NS / CLK_PERIOD_NS < 1) ? 1 : T_W_NS / CLK_PERIOD_NS;

  // Command state of the core
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PAGE_OPEN = 3'b010,
    ST_WRITING = 3'b100
  } frcu_state_type;
endpackage

// ### frcu_link_if.sv
// Signals passed between the serial link logic and the register core
`timescale 1ns/100ps
interface frcu_link_if;
  logic [7:0] op;
  logic [7:0] d0;
  logic [7:0] d1;
  logic [7:0] d2;
  logic [5:0] nbits;
  logic [7:0] snap_sr1;
  logic [7:0] snap_sr2;
  logic [7:0] snap_cr;
  logic [7:0] snap_page;
  logic req_tgl;
  logic ack_tgl;
  modport link (output op, d0, d1, d2, nbits, ack_tgl,
                input snap_sr1, snap_sr2, snap_cr, snap_page, req_tgl);
  modport core (input op, d0, d1, d2, nbits, ack_tgl,
                output snap_sr1, snap_sr2, snap_cr, snap_page, req_tgl);
endinterface

// ### frcu_link.sv
// Serial link logic on the host clock: frame capture and register read-out
`timescale 1ns/100ps
module frcu_link import frcu_pkg::*; (
  input wire logic sck,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe_n,
  frcu_link_if.link lk
);
  logic frame_rst_n;
  logic [5:0] cnt;
  logic [6:0] sh;
  logic [7:0] cur_byte;
  logic rd_mode;
  logic [7:0] out_byte;
  logic req_s1;
  logic req_s2;
  logic [7:0] sh_sr1;
  logic [7:0] sh_sr2;
  logic [7:0] sh_cr;
  logic [7:0] sh_page;

  // Byte selected for read-out by opcode
  function automatic logic [7:0] pick(input logic [7:0] op);
    case (op)
      OP_RD_STATUS_ONE: pick = sh_sr1;
      // RL3: status two read
      OP_RD_STATUS_TWO: pick = sh_sr2;
      // RL4: configuration read
      OP_RD_CONFIG: pick = sh_cr;
      // RL5: page register read
      OP_RD_PAGE: pick = sh_page;
      default: pick = 8'h00;
    endcase
  endfunction

  function automatic logic is_read(input logic [7:0] op);
    is_read = (op == OP_RD_STATUS_ONE) || (op == OP_RD_STATUS_TWO) ||
              (op == OP_RD_CONFIG) || (op == OP_RD_PAGE);
  endfunction

  // Deselect clears the frame state at once, since the clock stops with it
  assign frame_rst_n = nrst & ~cs_n;
  assign cur_byte = {sh, si};

  // Bit counter; wraps within the upper range so long reads keep byte phase
  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cnt <= 6'h00;
      rd_mode <= 1'b0;
    end else begin
      cnt <= (cnt == CNT_LAST) ? CNT_WRAP : cnt + 6'h01;
      if (cnt == 6'h07) begin
        rd_mode <= is_read(cur_byte);
      end
    end
  end

  // Frame capture; held after deselect so the core can read it
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      sh <= 7'h00;
      lk.op <= 8'h00;
      lk.d0 <= 8'h00;
      lk.d1 <= 8'h00;
      lk.d2 <= 8'h00;
      lk.nbits <= 6'h00;
      out_byte <= 8'h00;
    end else begin
      sh <= cur_byte[6:0];
      lk.nbits <= (cnt == CNT_LAST) ? CNT_LAST : cnt + 6'h01;
      case (cnt)
        6'h07: lk.op <= cur_byte;
        6'h0f: lk.d0 <= cur_byte;
        6'h17: lk.d1 <= cur_byte;
        6'h1f: lk.d2 <= cur_byte;
        default: ;
      endcase
      // RL2: fresh snapshot taken at every byte boundary
      if (cnt[2:0] == 3'h7) begin
        out_byte <= pick((cnt == 6'h07) ? cur_byte : lk.op);
      end
    end
  end

  // Shadow copy of the registers, refreshed by toggle handshake
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      lk.ack_tgl <= 1'b0;
      {sh_sr1, sh_sr2, sh_cr, sh_page} <= 32'h0000_0000;
    end else begin
      req_s1 <= lk.req_tgl;
      req_s2 <= req_s1;
      if (req_s2 != lk.ack_tgl) begin
        {sh_sr1, sh_sr2, sh_cr, sh_page} <= {lk.snap_sr1, lk.snap_sr2, lk.snap_cr, lk.snap_page};
        lk.ack_tgl <= req_s2;
      end
    end
  end

  // RL1: output bits change on the falling edge, MSB first
  always_ff @(negedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      so <= 1'b0;
    end else if (rd_mode) begin
      so <= out_byte[3'h7 - cnt[2:0]];
    end
  end

  assign so_oe_n = ~(rd_mode & ~cs_n);
endmodule

// ### frcu_host.sv
// Host controller model that drives the serial link in clock mode 0
`timescale 1ns/100ps
module frcu_host (
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  localparam time HALF = 32ns;

  // The link clock stands low outside frames
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b1;
  end

  // One frame: opcode, then nb data bits MSB first; rd keeps the last 16 bits seen
  // chip select rises right after the last data bit
  task automatic xfer(input logic [7:0] op, input logic [23:0] wd, input int nb,
                      output logic [15:0] rd);
    logic [31:0] sh;
    sh = {op, wd};
    rd = 16'h0000;
    cs_n = 1'b0;
    for (int i = 0; i < 8 + nb; i++) begin
      si = sh[31];
      sh = sh << 1;
      #HALF sck = 1'b1;
      rd = {rd[14:0], so};
      #HALF sck = 1'b0;
    end
    #HALF cs_n = 1'b1;
    // Released line shows the opposite of its last bit, never a stale copy
    si = ~si;
    // Deselect time well above the four system cycles the unit needs
    #200ns;
  endtask
endmodule

// ### frcu_core_tb.sv
// Self-checking bench for the flash register command unit
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module frcu_core_tb import frcu_pkg::*;;
  localparam logic [23:0] NOD = 24'h000000;
  logic mclk, nrst, sck, cs_n, si, so, wp_n, busy, fault, ext_addr_en, quad_enable;
  logic [1:0] page_addr_bits;
  logic [2:0] block_protect;
  logic [15:0] rd;
  logic so_oe_n;
  int errors = 0;
  int tests_run = 0;

  frcu_host host (.sck(sck), .cs_n(cs_n), .si(si), .so(so));
  // Short timed write so the non-volatile path finishes in 2 us
  frcu_core #(.TW_CYCLES(100), .TCS_CYCLES(2)) uut (.mclk(mclk), .nrst(nrst), .sck(sck),
    .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n), .wp_n(wp_n), .embedded_busy(busy),
    .reg_write_fault(fault), .ext_addr_en(ext_addr_en), .page_addr_bits(page_addr_bits),
    .quad_enable(quad_enable), .block_protect(block_protect));

  // System clock, 50 MHz
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic print_verdict;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmd(input logic [7:0] op, input logic [23:0] wd, input int nb);
    host.xfer(op, wd, nb, rd);
  endtask

  task automatic rd_chk(input logic [7:0] op, input logic [7:0] exp);
    host.xfer(op, NOD, 8, rd);
    `CHK(rd[7:0], exp)
  endtask

  // Side inputs change on the falling edge, away from sampling
  task automatic pins(input logic w, input logic b, input logic f);
    @(negedge mclk);
    wp_n = w;
    busy = b;
    fault = f;
  endtask

  // Poll status one until the write is over; a bounded poll avoids a hang
  task automatic wait_done;
    int n;
    n = 0;
    rd = 16'h0001;
    while (rd[0] !== 1'b0 && n < 20) begin
      host.xfer(OP_RD_STATUS_ONE, NOD, 8, rd);
      n++;
    end
    if (rd[0] !== 1'b0) begin
      errors++;
      print_verdict();
    end
  endtask

  task automatic wr(input logic [23:0] wd, input int nb);
    cmd(OP_WR_ENABLE, NOD, 0);
    cmd(OP_WR_REGS, wd, nb);
  endtask

  task automatic t_reset_reads;
    logic [7:0] ops [4] = '{OP_RD_STATUS_ONE, OP_RD_STATUS_TWO, OP_RD_CONFIG, OP_RD_PAGE};
    foreach (ops[i]) rd_chk(ops[i], 8'h00);
    `CHK({ext_addr_en, quad_enable, block_protect}, 5'h00)
  endtask

  // Output driver is on only while read data shifts; sampled between link edges
  task automatic t_out_enable;
    `CHK(so_oe_n, 1'b1)
    fork
      host.xfer(OP_RD_CONFIG, NOD, 8, rd);
      begin
        #780ns;
        `CHK(so_oe_n, 1'b0)
      end
    join
    `CHK(so_oe_n, 1'b1)
  endtask

  task automatic t_page_write;
    pins(1'b1, 1'b1, 1'b0);
    cmd(OP_WR_PAGE, 24'h830000, 8);
    host.xfer(OP_RD_PAGE, NOD, 16, rd);
    `CHK(rd, 16'h8383)
    `CHK({ext_addr_en, page_addr_bits}, 3'b100)
    rd_chk(OP_RD_STATUS_ONE, 8'h01);
    pins(1'b1, 1'b0, 1'b0);
    cmd(OP_WR_PAGE, 24'h020000, 8);
    `CHK({ext_addr_en, page_addr_bits}, 3'b010)
  endtask

  task automatic t_timed_write;
    cmd(OP_WR_REGS, 24'h7f0000, 8);
    rd_chk(OP_RD_STATUS_ONE, 8'h00);
    cmd(OP_WR_ENABLE, NOD, 0);
    rd_chk(OP_RD_STATUS_ONE, 8'h02);
    cmd(OP_WR_REGS, 24'h7f0000, 8);
    rd_chk(OP_RD_STATUS_ONE, 8'h1f);
    // One long read spans the end of the write: the last byte must be fresh
    host.xfer(OP_RD_STATUS_ONE, NOD, 64, rd);
    `CHK(rd[7:0], 8'h1c)
    `CHK(block_protect, 3'b111)
  endtask

  task automatic t_lengths;
    wr(24'h1c0200, 16);
    rd_chk(OP_RD_STATUS_ONE, 8'h1c);
    rd_chk(OP_RD_CONFIG, 8'h02);
    `CHK(quad_enable, 1'b1)
    wr(24'h000000, 8);
    rd_chk(OP_RD_STATUS_ONE, 8'h1e);
    cmd(OP_WR_REGS, 24'h005500, 12);
    rd_chk(OP_RD_STATUS_ONE, 8'h1e);
    cmd(OP_WR_REGS, 24'h000055, 24);
    wait_done();
    `CHK(rd[7:0], 8'h00)
    rd_chk(OP_RD_STATUS_TWO, 8'h55);
    rd_chk(OP_RD_CONFIG, 8'h00);
  endtask

  task automatic t_protect;
    wr(24'h800200, 16);
    wait_done();
    pins(1'b0, 1'b0, 1'b0);
    wr(24'h840200, 16);
    wait_done();
    `CHK(rd[7:0], 8'h84)
    wr(24'h800000, 16);
    wait_done();
    `CHK(quad_enable, 1'b0)
    wr(24'h8c0000, 8);
    rd_chk(OP_RD_STATUS_ONE, 8'h82);
    pins(1'b1, 1'b0, 1'b0);
    cmd(OP_WR_REGS, 24'h840000, 8);
    wait_done();
    `CHK(rd[7:0], 8'h84)
  endtask

  task automatic t_page_access;
    cmd(OP_WR_PAGE, 24'h800000, 8);
    cmd(OP_PAGE_ACCESS, NOD, 0);
    cmd(OP_WR_REGS, 24'h7dff00, 16);
    rd_chk(OP_RD_PAGE, 8'h81);
    rd_chk(OP_RD_STATUS_ONE, 8'h84);
    cmd(OP_PAGE_ACCESS, NOD, 0);
    rd_chk(OP_RD_STATUS_ONE, 8'h84);
    cmd(OP_WR_REGS, 24'h020000, 8);
    rd_chk(OP_RD_PAGE, 8'h81);
    `CHK({ext_addr_en, page_addr_bits}, 3'b100)
    pins(1'b1, 1'b1, 1'b0);
    cmd(OP_PAGE_ACCESS, NOD, 0);
    cmd(OP_WR_REGS, 24'h020000, 8);
    pins(1'b1, 1'b0, 1'b1);
    rd_chk(OP_RD_PAGE, 8'h81);
    // A failing write must leave an error flag behind
    wr(24'h000000, 8);
    wait_done();
    pins(1'b1, 1'b0, 1'b0);
    `CHK(rd[7:0], 8'h40)
    cmd(OP_PAGE_ACCESS, NOD, 0);
    cmd(OP_WR_REGS, 24'h030000, 8);
    rd_chk(OP_RD_PAGE, 8'h81);
  endtask

  // Reset for 16 cycles, then the scenarios in turn
  initial begin
    nrst = 1'b0;
    wp_n = 1'b1;
    busy = 1'b0;
    fault = 1'b0;
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    nrst = 1'b1;
    #207ns;
    t_reset_reads();
    t_out_enable();
    t_page_write();
    t_timed_write();
    t_lengths();
    t_protect();
    t_page_access();
    print_verdict();
  end
endmodule
